// >>> shared/seq_pkg.sv
// Constants shared by the control sequencer, its timing source and its register slave
package seq_pkg;

	// Clock and documented timing figures
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SRC_PERIOD_US = 50;
	localparam int SRC_WIDTH_US = 15;
	localparam int ADVANCE_US = 15;
	localparam int RELOAD_US = 30;
	// Cycle counts derived from the figures; all are exact multiples of the period
	localparam int SRC_PERIOD_CYC = SRC_PERIOD_US * 1000000 / CLK_PERIOD_PS;
	localparam int SRC_WIDTH_CYC = SRC_WIDTH_US * 1000000 / CLK_PERIOD_PS;
	localparam int ADVANCE_CYC = ADVANCE_US * 1000000 / CLK_PERIOD_PS;
	localparam int RELOAD_CYC = RELOAD_US * 1000000 / CLK_PERIOD_PS;

	// Widths of the sequencer registers
	localparam int OPCODE_W = 6;
	localparam int DIST_W = 4;
	localparam int ADDER_W = 2;
	localparam int REP_W = 7;
	localparam int PADDR_W = 6;
	localparam int MADDR_W = 7;

	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] START_OFS = 8'h04;
	localparam logic [7:0] PRESET_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0c;
	localparam logic [7:0] COUNTS_OFS = 8'h10;

	// Control register fields and reset value
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_STEP_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;

	// Status register fields
	localparam int STAT_PHASE_BIT = 0;
	localparam int STAT_ADDER_LSB = 1;
	localparam int STAT_RELOAD_BIT = 3;
	localparam int STAT_STEPOK_BIT = 4;

	// Counter snapshot field positions
	localparam int CNT_OPCODE_LSB = 0;
	localparam int CNT_DIST_LSB = 6;
	localparam int CNT_REP_LSB = 10;
	localparam int CNT_P_LSB = 17;
	localparam int CNT_M_LSB = 23;

	// Acquisition distributor states
	localparam logic [3:0] ACQ_CLEAR_M = 4'h0;
	localparam logic [3:0] ACQ_P_TO_M = 4'h1;
	localparam logic [3:0] ACQ_READ_OP = 4'h2;
	localparam logic [3:0] ACQ_LOAD_OP = 4'h3;
	localparam logic [3:0] ACQ_INC_M = 4'h4;
	localparam logic [3:0] ACQ_READ_ADR = 4'h5;
	localparam logic [3:0] ACQ_LOAD_ADR = 4'h6;
	localparam logic [3:0] DIST_LAST = 4'hf;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Reload sequencing states, Gray coded
	typedef enum logic [1:0] {
		RL_IDLE = 2'b00,
		RL_WAIT = 2'b01,
		RL_APPLY = 2'b11
	} reload_state_t;

endpackage

// >>> logic/timing_source.sv
// Free-running pulse source: fixed width pulses at a fixed repetition period
`timescale 1ns/1ps
`default_nettype none
module timing_source #(
	parameter int PERIOD = 10000,
	parameter int WIDTH = 3000
) (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	output logic level_r, // High for WIDTH cycles of each period
	output logic rise_r, // First cycle of a pulse
	output logic fall_r // First cycle after a pulse
);
	localparam int CW = $clog2(PERIOD);
	localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
	localparam logic [CW-1:0] WEND = CW'(WIDTH);

	logic [CW-1:0] cnt_r;

	// Period counter wraps; no stop, the source never pauses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
		end else if (cnt_r == LAST) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// Outputs registered so the pulse edges are glitch free
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_r <= 1'b0;
			rise_r <= 1'b0;
			fall_r <= 1'b0;
		end else begin
			level_r <= cnt_r < WEND;
			rise_r <= cnt_r == '0;
			fall_r <= cnt_r == WEND;
		end
	end
endmodule
`default_nettype wire

// >>> logic/axil_slave.sv
// AXI4-Lite slave front end: one write and one read in flight, fixed latency
`timescale 1ns/1ps
`default_nettype none
module axil_slave
	import seq_pkg::*;
(
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [7:0] awaddr, // Write address
	input wire logic awvalid, // Write address valid
	output logic awready, // Write address ready
	input wire logic [31:0] wdata, // Write data
	input wire logic [3:0] wstrb, // Write byte strobes
	input wire logic wvalid, // Write data valid
	output logic wready, // Write data ready
	output logic [1:0] bresp, // Write response
	output logic bvalid, // Write response valid
	input wire logic bready, // Write response ready
	input wire logic [7:0] araddr, // Read address
	input wire logic arvalid, // Read address valid
	output logic arready, // Read address ready
	output logic [31:0] rdata, // Read data
	output logic [1:0] rresp, // Read response
	output logic rvalid, // Read data valid
	input wire logic rready, // Read data ready
	output logic wr_pulse_r, // One-cycle register write strobe
	output logic [7:0] wr_addr_r, // Captured write address
	output logic [31:0] wr_data_r, // Captured write data
	output logic [3:0] wr_strb_r, // Captured byte strobes
	input wire logic wr_hit, // Captured write address is mapped
	input wire logic [31:0] rd_data, // Read data for araddr
	input wire logic rd_hit // araddr is mapped
);
	logic aw_got_r;
	logic w_got_r;

	// Write side: address and data in either order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			wr_pulse_r <= 1'b0;
			wr_addr_r <= '0;
			wr_data_r <= '0;
			wr_strb_r <= '0;
		end else begin
			wr_pulse_r <= 1'b0;
			if (awvalid && awready) begin
				aw_got_r <= 1'b1;
				awready <= 1'b0;
				wr_addr_r <= awaddr;
			end
			if (wvalid && wready) begin
				w_got_r <= 1'b1;
				wready <= 1'b0;
				wr_data_r <= wdata;
				wr_strb_r <= wstrb;
			end
			if (aw_got_r && w_got_r && !bvalid) begin
				wr_pulse_r <= wr_hit;
				bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
				bvalid <= 1'b1;
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
			end
			// Ready returns only after the response, so one write at a time
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// Read side: data sampled at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_hit ? rd_data : 32'h0000_0000;
			rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> logic/cpu_control_sequencer.sv
// Control sequencer: phase flag, opcode decode, distributor, adder timing, counters
// Function
// - Acquisition disables opcode decode, acquisition subcommands only
// - Commands are decoded opcode ANDed with phase
// - Distributor pulse is state decode AND timing
// - Six-bit opcode register feeds command decoder
// - Four-bit distributor counter, sixteen pulses, starts zero
// - Last acquisition pulse sets phase, clears distributor
// - Distributor advances 15 us after each pulse
// - Reload to earlier state lands 30 us later
// - Distributor holds while adder pulses are issued
// - Source pulses 15 us wide every 50 us
// - Basic pulse only while adder counter zero
// - Two-bit adder counter counts three on request
// - After third count adder counter clears, distributor resumes
// - Single-step mode releases one adder pulse per start
// - Seven-bit repetition down-counter, preset or set
// - Repetition counter msb comes from opcode lsb
// - Repetition counter decrements; zero returns to acquisition
// - Program address counter preset, steps, jumps
// - Memory address cleared, then program address shifted in
// - Acquisition increments memory address to odd cell
// - Opcode and operand address loaded; program address increments
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cpu_control_sequencer
	import seq_pkg::*;
#(
	parameter int PERIOD_CYC = SRC_PERIOD_CYC,
	parameter int WIDTH_CYC = SRC_WIDTH_CYC,
	parameter int RELOAD_DLY_CYC = RELOAD_CYC
) (
	input wire logic aclk, // System clock, 200 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // AXI write address
	input wire logic s_axi_awvalid, // AXI write address valid
	output logic s_axi_awready, // AXI write address ready
	input wire logic [31:0] s_axi_wdata, // AXI write data
	input wire logic [3:0] s_axi_wstrb, // AXI write strobes
	input wire logic s_axi_wvalid, // AXI write data valid
	output logic s_axi_wready, // AXI write data ready
	output logic [1:0] s_axi_bresp, // AXI write response
	output logic s_axi_bvalid, // AXI write response valid
	input wire logic s_axi_bready, // AXI write response ready
	input wire logic [7:0] s_axi_araddr, // AXI read address
	input wire logic s_axi_arvalid, // AXI read address valid
	output logic s_axi_arready, // AXI read address ready
	output logic [31:0] s_axi_rdata, // AXI read data
	output logic [1:0] s_axi_rresp, // AXI read response
	output logic s_axi_rvalid, // AXI read data valid
	input wire logic s_axi_rready, // AXI read data ready
	input wire logic [OPCODE_W-1:0] xchg_data, // Word from the exchange register
	input wire logic add_req, // Execution asks for an add sequence
	input wire logic reload_req, // Execution asks for a distributor reload
	input wire logic [DIST_W-1:0] reload_state, // Earlier distributor state to reload
	input wire logic count_set, // Set repetition counter during execution
	input wire logic load_count_instr, // Preset repetition counter for input/output
	input wire logic [REP_W-2:0] count_value, // Lower bits of the repetition count
	input wire logic jump_take, // Execute a jump to jump_addr
	input wire logic [PADDR_W-1:0] jump_addr, // Jump target program address
	output logic phase_flag, // 0 acquisition, 1 execution
	output logic [(1<<OPCODE_W)-1:0] command_r, // One-hot instruction commands
	output logic [(1<<DIST_W)-1:0] distributor_pulse, // Distributor pulses, one hot
	output logic basic_timing_pulse, // Basic timing pulse
	output logic adder_pulse_first, // First adder timing pulse
	output logic adder_pulse_second, // Second adder timing pulse
	output logic adder_pulse_third, // Third adder timing pulse
	output logic [MADDR_W-1:0] mem_addr_r, // Memory address counter
	output logic mem_read_r, // Memory read strobe
	output logic repetition_counter_msb // Top bit of the repetition counter
);
	logic src_level;
	logic src_rise;
	logic src_fall;
	logic wr_pulse;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_hit;
	logic [31:0] rd_data;
	logic rd_hit;

	logic run_r;
	logic step_mode_r;
	logic step_ok_r;
	logic [OPCODE_W-1:0] opcode_r;
	logic [DIST_W-1:0] dist_r;
	logic [ADDER_W-1:0] adder_timing_counter;
	logic [REP_W-1:0] rep_r;
	logic [PADDR_W-1:0] paddr_r;
	logic route_basic_r;
	logic route_adder_r;
	logic [DIST_W-1:0] rl_state_r;
	logic [$clog2(RELOAD_DLY_CYC+1)-1:0] rl_cnt_r;
	reload_state_t rl_fsm_r;
	reload_state_t rl_fsm_nxt;

	logic sel_basic;
	logic sel_adder;
	logic route_basic;
	logic route_adder;
	logic dp_start;
	logic basic_fall;
	logic adder_fall;
	logic rl_done;
	logic phase_end;
	logic [7:0] cnt_ofs;

	localparam logic [$clog2(RELOAD_DLY_CYC+1)-1:0] RL_LAST =
		($clog2(RELOAD_DLY_CYC+1))'(RELOAD_DLY_CYC - 2);

	timing_source #(
		.PERIOD(PERIOD_CYC),
		.WIDTH(WIDTH_CYC)
	) u_src (
		.aclk(aclk),
		.aresetn(aresetn),
		.level_r(src_level),
		.rise_r(src_rise),
		.fall_r(src_fall)
	);

	axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.wr_pulse_r(wr_pulse),
		.wr_addr_r(wr_addr),
		.wr_data_r(wr_data),
		.wr_strb_r(wr_strb),
		.wr_hit(wr_hit),
		.rd_data(rd_data),
		.rd_hit(rd_hit)
	);

	// Clock pulse routing, decided at the start of each source pulse
	assign sel_basic = run_r && (adder_timing_counter == '0);
	assign sel_adder = run_r && (adder_timing_counter != '0) && (step_ok_r || !step_mode_r);
	assign route_basic = src_rise ? sel_basic : route_basic_r;
	assign route_adder = src_rise ? sel_adder : route_adder_r;
	assign dp_start = src_rise && sel_basic;
	assign basic_fall = src_fall && route_basic_r;
	assign adder_fall = src_fall && route_adder_r;
	assign rl_done = (rl_fsm_r == RL_APPLY);
	// Phase drops at this edge; commands go dark with it, not one cycle later
	assign phase_end = phase_flag && (rl_done ? (rep_r == REP_W'(1)) :
		(basic_fall && rl_fsm_r == RL_IDLE && dist_r == DIST_LAST));

	// Route is held for the whole pulse so a pulse is never split between uses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			route_basic_r <= 1'b0;
			route_adder_r <= 1'b0;
		end else if (src_rise) begin
			route_basic_r <= sel_basic;
			route_adder_r <= sel_adder;
		end
	end

	// Timing pulse outputs, one register stage behind the source
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			basic_timing_pulse <= 1'b0;
			adder_pulse_first <= 1'b0;
			adder_pulse_second <= 1'b0;
			adder_pulse_third <= 1'b0;
		end else begin
			basic_timing_pulse <= src_level && route_basic;
			adder_pulse_first <= src_level && route_adder && (adder_timing_counter == 2'h1);
			adder_pulse_second <= src_level && route_adder && (adder_timing_counter == 2'h2);
			adder_pulse_third <= src_level && route_adder && (adder_timing_counter == 2'h3);
		end
	end

	// Distributor pulses: one state decode per bit, gated by the basic pulse
	genvar k;
	generate
		for (k = 0; k < (1 << DIST_W); k++) begin : g_dp
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					distributor_pulse[k] <= 1'b0;
				end else begin
					distributor_pulse[k] <= src_level && route_basic && (dist_r == DIST_W'(k));
				end
			end
		end
	endgenerate

	// Commands: decoder output ANDed with the phase flag, dark in acquisition
	genvar c;
	generate
		for (c = 0; c < (1 << OPCODE_W); c++) begin : g_cmd
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					command_r[c] <= 1'b0;
				end else begin
					command_r[c] <= phase_flag && !phase_end &&
						(opcode_r == OPCODE_W'(c));
				end
			end
		end
	endgenerate

	// Adder timing counter: parked at zero until an add, then 1, 2, 3 and clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			adder_timing_counter <= '0;
		end else if (basic_fall && phase_flag && add_req && adder_timing_counter == '0) begin
			adder_timing_counter <= 2'h1;
		end else if (adder_fall) begin
			adder_timing_counter <= adder_timing_counter + 1'b1;
		end
	end

	// Single-step release: each adder pulse uses up the grant, start restores it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_ok_r <= 1'b0;
		end else if (wr_pulse && wr_addr == START_OFS && wr_strb[0] && wr_data[0]) begin
			step_ok_r <= 1'b1;
		end else if (adder_fall) begin
			step_ok_r <= 1'b0;
		end
	end

	// Reload sequencer state
	always_comb begin
		rl_fsm_nxt = rl_fsm_r;
		unique case (rl_fsm_r)
			RL_IDLE: begin
				if (dp_start && phase_flag && reload_req) begin
					rl_fsm_nxt = RL_WAIT;
				end
			end
			RL_WAIT: begin
				if (rl_cnt_r == RL_LAST) begin
					rl_fsm_nxt = RL_APPLY;
				end
			end
			RL_APPLY: begin
				rl_fsm_nxt = RL_IDLE;
			end
			default: begin
				rl_fsm_nxt = RL_IDLE;
			end
		endcase
	end

	// Reload delay counter runs from the initiating pulse; the target is captured then
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rl_fsm_r <= RL_IDLE;
			rl_cnt_r <= '0;
			rl_state_r <= '0;
		end else begin
			rl_fsm_r <= rl_fsm_nxt;
			if (rl_fsm_r == RL_IDLE) begin
				rl_cnt_r <= '0;
				rl_state_r <= reload_state;
			end else begin
				rl_cnt_r <= rl_cnt_r + 1'b1;
			end
		end
	end

	// Phase flag and distributor; a pending reload replaces the normal advance
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_flag <= 1'b0;
			dist_r <= '0;
		end else if (rl_done) begin
			if (rep_r == {{(REP_W-1){1'b0}}, 1'b1}) begin
				phase_flag <= 1'b0;
				dist_r <= '0;
			end else begin
				dist_r <= rl_state_r;
			end
		end else if (basic_fall && rl_fsm_r == RL_IDLE) begin
			// Falling edge of the 15 us pulse is the advance instant
			if (dist_r == DIST_LAST) begin
				phase_flag <= !phase_flag;
				dist_r <= '0;
			end else begin
				dist_r <= dist_r + 1'b1;
			end
		end
	end

	// Repetition counter: set with msb from opcode lsb, decremented per repeat
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rep_r <= '0;
		end else if (rl_done && rep_r != '0) begin
			rep_r <= rep_r - 1'b1;
		end else if ((count_set && phase_flag) || load_count_instr) begin
			rep_r <= {opcode_r[0], count_value};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			repetition_counter_msb <= 1'b0;
		end else begin
			repetition_counter_msb <= rep_r[REP_W-1];
		end
	end

	// Acquisition subcommands, issued at the start of each distributor pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			opcode_r <= '0;
			mem_addr_r <= '0;
			mem_read_r <= 1'b0;
		end else begin
			mem_read_r <= 1'b0;
			if (dp_start && !phase_flag) begin
				unique case (dist_r)
					ACQ_CLEAR_M: mem_addr_r <= '0;
					ACQ_P_TO_M: mem_addr_r <= {paddr_r, 1'b0};
					ACQ_READ_OP: mem_read_r <= 1'b1;
					ACQ_LOAD_OP: opcode_r <= xchg_data;
					ACQ_INC_M: mem_addr_r <= mem_addr_r + 1'b1;
					ACQ_READ_ADR: mem_read_r <= 1'b1;
					ACQ_LOAD_ADR: mem_addr_r <= {1'b0, xchg_data};
					default: mem_read_r <= 1'b0;
				endcase
			end
		end
	end

	// Program address: operator preset, acquisition step, or jump
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			paddr_r <= '0;
		end else if (wr_pulse && wr_addr == PRESET_OFS && wr_strb[0]) begin
			paddr_r <= wr_data[PADDR_W-1:0];
		end else if (jump_take && phase_flag) begin
			paddr_r <= jump_addr;
		end else if (dp_start && !phase_flag && dist_r == ACQ_LOAD_ADR) begin
			paddr_r <= paddr_r + 1'b1;
		end
	end

	// Control register: run gate and single-step mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_r <= CTRL_RST[CTRL_RUN_BIT];
			step_mode_r <= CTRL_RST[CTRL_STEP_BIT];
		end else if (wr_pulse && wr_addr == CTRL_OFS && wr_strb[0]) begin
			run_r <= wr_data[CTRL_RUN_BIT];
			step_mode_r <= wr_data[CTRL_STEP_BIT];
		end
	end

	// Address decode for both bus directions
	assign wr_hit = (wr_addr == CTRL_OFS) || (wr_addr == START_OFS) ||
		(wr_addr == PRESET_OFS);
	assign cnt_ofs = s_axi_araddr;
	assign rd_hit = (cnt_ofs == CTRL_OFS) || (cnt_ofs == START_OFS) ||
		(cnt_ofs == PRESET_OFS) || (cnt_ofs == STATUS_OFS) || (cnt_ofs == COUNTS_OFS);

	// Read data mux; start reads as zero since it only carries a strobe
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (cnt_ofs)
			CTRL_OFS: begin
				rd_data[CTRL_RUN_BIT] = run_r;
				rd_data[CTRL_STEP_BIT] = step_mode_r;
			end
			PRESET_OFS: rd_data[PADDR_W-1:0] = paddr_r;
			STATUS_OFS: begin
				rd_data[STAT_PHASE_BIT] = phase_flag;
				rd_data[STAT_ADDER_LSB +: ADDER_W] = adder_timing_counter;
				rd_data[STAT_RELOAD_BIT] = rl_fsm_r != RL_IDLE;
				rd_data[STAT_STEPOK_BIT] = step_ok_r;
			end
			COUNTS_OFS: begin
				rd_data[CNT_OPCODE_LSB +: OPCODE_W] = opcode_r;
				rd_data[CNT_DIST_LSB +: DIST_W] = dist_r;
				rd_data[CNT_REP_LSB +: REP_W] = rep_r;
				rd_data[CNT_P_LSB +: PADDR_W] = paddr_r;
				rd_data[CNT_M_LSB +: MADDR_W] = mem_addr_r;
			end
			default: rd_data = 32'h0000_0000;
		endcase
	end
endmodule
`default_nettype wire

// >>> verif/seq_sva.sv
// Port-level checker for the control sequencer
`timescale 1ns/1ps
`default_nettype none
module seq_sva #(
	parameter int WIDTH_CYC = 3000
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	input wire logic phase_flag, // Phase
	input wire logic [63:0] command_r, // Commands
	input wire logic [15:0] distributor_pulse, // Distributor pulses
	input wire logic basic_timing_pulse, // Basic pulse
	input wire logic adder_pulse_first, // Adder pulse 1
	input wire logic adder_pulse_second, // Adder pulse 2
	input wire logic adder_pulse_third // Adder pulse 3
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [15:0] hi_cnt_r;
	// Length of the current basic pulse; a repetition count would not scale
	always_ff @(posedge aclk) begin
		if (!aresetn || !basic_timing_pulse) hi_cnt_r <= 16'h0000;
		else hi_cnt_r <= hi_cnt_r + 16'h0001;
	end
	cmd_in_acq_a: assert property (!phase_flag |-> command_r == 64'h0)
		else $error("command active in acquisition");
	cmd_onehot_a: assert property ($onehot0(command_r))
		else $error("more than one command");
	dp_with_basic_a: assert property (|distributor_pulse |-> basic_timing_pulse && $onehot(distributor_pulse))
		else $error("distributor pulse without basic pulse");
	basic_excl_a: assert property (basic_timing_pulse |-> !(adder_pulse_first | adder_pulse_second | adder_pulse_third))
		else $error("basic and adder pulse together");
	adder_onehot_a: assert property ($onehot0({adder_pulse_first, adder_pulse_second, adder_pulse_third}))
		else $error("two adder pulses together");
	pulse_width_a: assert property ($fell(basic_timing_pulse) |-> hi_cnt_r == WIDTH_CYC[15:0])
		else $error("basic pulse width wrong");
	exec_start_a: assert property ($rose(phase_flag) |-> ##[1:60] distributor_pulse[0])
		else $error("execution does not start at state zero");
	adder_done_a: assert property ($fell(adder_pulse_third) |-> ##[1:60] basic_timing_pulse)
		else $error("basic pulse not resumed");
	third_after_a: assert property ($rose(adder_pulse_third) |-> distributor_pulse == 16'h0000)
		else $error("distributor pulse during adder step");
	// Main scenarios reached
	cover property ($rose(phase_flag));
	cover property ($rose(adder_pulse_third));
	cover property ($fell(phase_flag));
endmodule
bind cpu_control_sequencer seq_sva #(.WIDTH_CYC(WIDTH_CYC)) seq_sva_inst (.aclk(aclk),
	.aresetn(aresetn), .phase_flag(phase_flag), .command_r(command_r),
	.distributor_pulse(distributor_pulse), .basic_timing_pulse(basic_timing_pulse),
	.adder_pulse_first(adder_pulse_first), .adder_pulse_second(adder_pulse_second),
	.adder_pulse_third(adder_pulse_third));
`default_nettype wire

// >>> verif/mem_model.sv
// Core memory behind the exchange register: even cells opcode, odd cells operand
`timescale 1ns/1ps
`default_nettype none
module mem_model #(
	parameter logic [5:0] OPC = 6'h05,
	parameter logic [5:0] OPND = 6'h2a
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	input wire logic [6:0] addr, // Memory address
	input wire logic rd, // Read strobe
	output logic [5:0] data // Exchange word
);
	// Word held until the next read; all ones after reset so a missed read shows
	always_ff @(posedge aclk) begin
		if (!aresetn) data <= 6'h3f;
		else if (rd) data <= addr[0] ? OPND : OPC;
	end
endmodule
`default_nettype wire

// >>> verif/tb_cpu_control_sequencer.sv
// Testbench: register bus, acquisition, adder steps and end of execution
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_control_sequencer;
	import seq_pkg::*;
	localparam logic [5:0] OPC = 6'h05;
	localparam logic [5:0] OPND = 6'h2a;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, phase_flag, basic, a1, a2, a3, mrd, msb;
	logic [1:0] bresp, rresp, r;
	logic add_req = 1'b0, count_set = 1'b0;
	logic [5:0] count_value = 6'h00, xchg;
	logic reload_req = 1'b0, load_cnt = 1'b0, jump_take = 1'b0;
	logic [3:0] wstrb = 4'hf, rl_st = 4'h0;
	logic [5:0] jump_addr = 6'h00;
	logic [63:0] command_r;
	logic [15:0] dp;
	logic [6:0] maddr;
	int num_errors = 0, n_checks = 0;
	cpu_control_sequencer #(.PERIOD_CYC(20), .WIDTH_CYC(6), .RELOAD_DLY_CYC(12))
		cpu_control_sequencer_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .xchg_data(xchg),
		.add_req(add_req), .reload_req(reload_req), .reload_state(rl_st), .count_set(count_set),
		.load_count_instr(load_cnt), .count_value(count_value), .jump_take(jump_take),
		.jump_addr(jump_addr), .phase_flag(phase_flag), .command_r(command_r),
		.distributor_pulse(dp), .basic_timing_pulse(basic), .adder_pulse_first(a1),
		.adder_pulse_second(a2), .adder_pulse_third(a3), .mem_addr_r(maddr),
		.mem_read_r(mrd), .repetition_counter_msb(msb));
	mem_model #(.OPC(OPC), .OPND(OPND)) mem_model_inst (.aclk(aclk), .aresetn(aresetn),
		.addr(maddr), .rd(mrd), .data(xchg));
	// 200 MHz clock
	initial begin
		forever #2.5 aclk = ~aclk;
	end
	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Each channel released at the edge where its ready is seen
	task wr(input logic [7:0] a, input logic [31:0] v);
		awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp; bready <= 1'b0;
		@(posedge aclk);
	endtask
	task rd(input logic [7:0] a);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata; r = rresp; rready <= 1'b0;
		@(posedge aclk);
	endtask
	// Waits end at the watchdog if the event never comes; loops see pre-edge values
	task wait_rd;
		do @(posedge aclk); while (!mrd);
	endtask
	task wait_sig(input int which, input logic lvl);
		do @(posedge aclk);
		while ((which == 0 ? phase_flag : which == 1 ? a1 : which == 2 ? a2 : a3) !== lvl);
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Whole run needs about 2500 cycles
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		summarize();
	end
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(CTRL_OFS); chk(d, 32'h0);
		rd(8'h20); chk({r, d}, {RESP_SLVERR, 32'h0});
		wr(8'h20, 32'h1); chk(r, RESP_SLVERR);
		wstrb <= 4'h0; wr(PRESET_OFS, 32'h9); chk(r, RESP_OKAY);
		wstrb <= 4'hf; rd(PRESET_OFS); chk(d, 32'h0);
		$display("test registers done");
		wr(PRESET_OFS, 32'h5);
		wr(CTRL_OFS, 32'h1);
		wait_rd; chk(maddr, 7'h0a);
		wait_rd; chk(maddr, 7'h0b);
		wait_sig(0, 1'b1); repeat (2) @(posedge aclk);
		chk(command_r, 64'h1 << OPC);
		rd(COUNTS_OFS); chk(d[5:0], OPC);
		chk({d[29:17], d[9:6]}, {1'b0, OPND, 6'h06, 4'h0});
		count_set <= 1'b1; count_value <= 6'h03; @(posedge aclk);
		count_set <= 1'b0; repeat (3) @(posedge aclk);
		chk(msb, OPC[0]);
		$display("test acquisition done");
		add_req <= 1'b1; wait_sig(1, 1'b1); add_req <= 1'b0;
		wait_sig(3, 1'b1); chk(a3, 1'b1);
		wr(CTRL_OFS, 32'h3); wr(START_OFS, 32'h1); add_req <= 1'b1;
		wait_sig(1, 1'b1); add_req <= 1'b0; repeat (60) @(posedge aclk);
		chk(a2, 1'b0);
		wr(START_OFS, 32'h1); wait_sig(2, 1'b1); chk(a2, 1'b1);
		wait_sig(2, 1'b0); wr(START_OFS, 32'h1); wait_sig(3, 1'b1); chk(a3, 1'b1);
		wr(CTRL_OFS, 32'h1);
		$display("test adder done");
		wait_sig(0, 1'b0); chk(phase_flag, 1'b0);
		wait_rd; chk(maddr, 7'h0c);
		$display("test execution end done");
		load_cnt <= 1'b1; count_value <= 6'h01; @(posedge aclk); load_cnt <= 1'b0;
		rd(COUNTS_OFS); chk(d[16:10], 7'h41);
		reload_req <= 1'b1; rl_st <= 4'h2; wait_sig(0, 1'b1);
		jump_addr <= 6'h10; jump_take <= 1'b1; @(posedge aclk); jump_take <= 1'b0;
		repeat (40) @(posedge aclk); rd(COUNTS_OFS); chk(d[9:6], 4'h2);
		wait_sig(0, 1'b0); rd(COUNTS_OFS); chk(d[16:6], 11'h000);
		wait_rd; chk(maddr, 7'h20);
		$display("test reload and jump done");
		summarize();
	end
endmodule
`default_nettype wire
